// *** core/oscsel_pkg.sv ***
/*
 * oscsel_pkg: constants for the oscillator source select control block.
 * Assumes a 16-bit control/status register reached over a plain strobe port.
 */
package oscsel_pkg;

    // source select encoding
    localparam logic [2:0] OSCSEL_SRC_FAST_RC  = 3'h0;
    localparam logic [2:0] OSCSEL_SRC_RC_PLL   = 3'h1;
    localparam logic [2:0] OSCSEL_SRC_PRI      = 3'h2;
    localparam logic [2:0] OSCSEL_SRC_PRI_PLL  = 3'h3;
    localparam logic [2:0] OSCSEL_SRC_SEC      = 3'h4;
    localparam logic [2:0] OSCSEL_SRC_LOW_RC   = 3'h5;
    localparam logic [2:0] OSCSEL_SRC_RSVD     = 3'h6;
    localparam logic [2:0] OSCSEL_SRC_RC_DIV   = 3'h7;

    // primary sub-mode encoding
    localparam logic [1:0] OSCSEL_PMODE_EXT    = 2'h0;
    localparam logic [1:0] OSCSEL_PMODE_XTAL   = 2'h1;
    localparam logic [1:0] OSCSEL_PMODE_FAST   = 2'h2;
    localparam logic [1:0] OSCSEL_PMODE_OFF    = 2'h3;

    // register map
    localparam logic [7:0] OSCSEL_CTRL_ADDR    = 8'h00;

    // field positions
    localparam int OSCSEL_CUR_LSB    = 12;
    localparam int OSCSEL_NEW_LSB    = 8;
    localparam int OSCSEL_SEL_LOCK   = 7;
    localparam int OSCSEL_IO_LOCK    = 6;
    localparam int OSCSEL_PLL_LOCK   = 5;
    localparam int OSCSEL_FAIL       = 3;
    localparam int OSCSEL_PRI_SLEEP  = 2;
    localparam int OSCSEL_SEC_EN     = 1;
    localparam int OSCSEL_SW_REQ     = 0;

    // reset values
    localparam logic [2:0]  OSCSEL_SRC_RST     = OSCSEL_SRC_RC_DIV;
    localparam logic [15:0] OSCSEL_RDATA_RST   = 16'h0000;

    // unlock keys, high byte pair then low byte pair
    localparam logic [7:0] OSCSEL_KEY_HI_1     = 8'h78;
    localparam logic [7:0] OSCSEL_KEY_HI_2     = 8'h9a;
    localparam logic [7:0] OSCSEL_KEY_LO_1     = 8'h46;
    localparam logic [7:0] OSCSEL_KEY_LO_2     = 8'h57;

    // timing counts
    localparam int OSCSEL_SETTLE_CYCLES = 10;
    localparam int OSCSEL_GATE_CYCLES   = 2;

    typedef enum logic [1:0] {
        OSCSEL_UL_IDLE,
        OSCSEL_UL_KEY1,
        OSCSEL_UL_OPEN
    } oscsel_unlock_t;

    typedef enum logic [2:0] {
        OSCSEL_SW_IDLE,
        OSCSEL_SW_CHECK,
        OSCSEL_SW_WAIT,
        OSCSEL_SW_SETTLE,
        OSCSEL_SW_GATE,
        OSCSEL_SW_MUX
    } oscsel_sw_t;

endpackage : oscsel_pkg

// *** core/oscsel_ctrl.sv ***
/*
 * oscsel_ctrl: oscillator source selection, clock switch sequencer and the
 * oscillator control/status register.
 * Assumes clock_i is the processor clock; oscillator ready, pll lock and the
 * new-source clock arrive asynchronously; configuration fields are static
 * from reset release on; fail detect comes from a monitor on clock_i.
 */
`timescale 1ns/100ps

module oscsel_ctrl
    import oscsel_pkg::*;
#(
    parameter int ADDR_W        = 8,
    parameter int SETTLE_CYCLES = OSCSEL_SETTLE_CYCLES,
    parameter int GATE_CYCLES   = OSCSEL_GATE_CYCLES
)(
    input  wire logic              clock_i,
    input  wire logic              rst_b_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [15:0]       wdata_i,
    input  wire logic [1:0]        wr_be_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    input  wire logic [2:0]        initial_source_cfg_i,
    input  wire logic [1:0]        primary_mode_cfg_i,
    input  wire logic [1:0]        switch_monitor_cfg_i,
    input  wire logic              osc_out_pin_function_cfg_i,
    input  wire logic              io_lock_one_way_cfg_i,
    input  wire logic [3:0]        osc_ready_i,
    input  wire logic              pll_lock_i,
    input  wire logic              new_clk_i,
    input  wire logic              clock_fail_i,
    input  wire logic              sleep_i,
    output logic [15:0]            rdata_o,
    output logic [2:0]             clk_mux_sel_o,
    output logic                   clk_gate_o,
    output logic [3:0]             osc_enable_o,
    output logic                   pll_enable_o,
    output logic [1:0]             primary_mode_o,
    output logic                   fail_safe_monitor_o,
    output logic                   io_lock_a_o,
    output logic                   fcy_o,
    output logic                   osc_output_pin_fcy_o
);

    localparam int SET_W  = $clog2(SETTLE_CYCLES + 1);
    localparam int GATE_W = $clog2(GATE_CYCLES + 1);
    localparam int SYN_W  = 6;

    if (ADDR_W < 8 || SETTLE_CYCLES < 1 || GATE_CYCLES < 1)
    begin : g_check
        $error("oscsel_ctrl: ADDR_W >= 8, SETTLE_CYCLES and GATE_CYCLES >= 1 required");
    end

    // osc_enable bit order: {low-power rc, fast rc, secondary, primary}
    function automatic logic [3:0] src_uses(input logic [2:0] src);
        logic [3:0] u;
        u = 4'h0;
        unique case (src)
            OSCSEL_SRC_FAST_RC, OSCSEL_SRC_RC_PLL, OSCSEL_SRC_RC_DIV: u = 4'h4;
            OSCSEL_SRC_PRI, OSCSEL_SRC_PRI_PLL:                       u = 4'h1;
            OSCSEL_SRC_SEC:                                           u = 4'h2;
            OSCSEL_SRC_LOW_RC:                                        u = 4'h8;
            OSCSEL_SRC_RSVD:                                        u = 4'h0;
        endcase
        return u;
    endfunction : src_uses

    function automatic logic src_pll(input logic [2:0] src, input logic [1:0] pmode);
        return (src == OSCSEL_SRC_RC_PLL) ||
               (src == OSCSEL_SRC_PRI_PLL && (pmode == OSCSEL_PMODE_XTAL ||
                                              pmode == OSCSEL_PMODE_EXT));
    endfunction : src_pll

    // configuration capture after reset release
    logic       cfg_loaded_ff;
    logic [2:0] init_src_ff;
    logic [1:0] pmode_ff;
    logic [1:0] swmon_ff;
    logic       pin_fn_ff;
    logic       one_way_ff;

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cfg_loaded_ff <= 1'b0;
            init_src_ff   <= OSCSEL_SRC_RST;
            pmode_ff      <= OSCSEL_PMODE_OFF;
            swmon_ff      <= 2'h3;
            pin_fn_ff     <= 1'b0;
            one_way_ff    <= 1'b1;
        end
        else if (!cfg_loaded_ff)
        begin
            cfg_loaded_ff <= 1'b1;
            init_src_ff   <= initial_source_cfg_i;
            pmode_ff      <= primary_mode_cfg_i;
            swmon_ff      <= switch_monitor_cfg_i;
            pin_fn_ff     <= osc_out_pin_function_cfg_i;
            one_way_ff    <= io_lock_one_way_cfg_i;
        end
    end

    logic sw_allowed;
    logic mon_on;
    assign sw_allowed = cfg_loaded_ff && !swmon_ff[1];
    assign mon_on     = cfg_loaded_ff && (swmon_ff == 2'h0);

    // three-stage input filter; the first stage feeds only the second
    logic [SYN_W-1:0] syn1_ff;
    logic [SYN_W-1:0] syn2_ff;
    logic [SYN_W-1:0] syn3_ff;
    logic [SYN_W-1:0] syn_ok_ff;
    logic [SYN_W-1:0] nxt_syn_ok;

    always_comb
    begin
        for (int i = 0; i < SYN_W; i++)
        begin
            nxt_syn_ok[i] = (syn2_ff[i] == syn3_ff[i]) ? syn2_ff[i] : syn_ok_ff[i];
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            syn1_ff   <= '0;
            syn2_ff   <= '0;
            syn3_ff   <= '0;
            syn_ok_ff <= '0;
        end
        else
        begin
            syn1_ff   <= {new_clk_i, pll_lock_i, osc_ready_i};
            syn2_ff   <= syn1_ff;
            syn3_ff   <= syn2_ff;
            syn_ok_ff <= nxt_syn_ok;
        end
    end

    logic [3:0] ready_s;
    logic       pll_lock_s;
    logic       new_clk_rise;
    assign ready_s      = syn_ok_ff[3:0];
    assign pll_lock_s   = syn_ok_ff[4];
    assign new_clk_rise = nxt_syn_ok[5] && !syn_ok_ff[5];

    // unlock sequencers, lane 1 = high byte, lane 0 = low byte
    oscsel_unlock_t ul_ff [2];
    logic [1:0]     lane_open;
    logic           reg_wr;
    logic           reg_rd;
    assign reg_wr = wr_i && (addr_i == ADDR_W'(OSCSEL_CTRL_ADDR));
    assign reg_rd = rd_i && (addr_i == ADDR_W'(OSCSEL_CTRL_ADDR));

    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            lane_open[i] = reg_wr && wr_be_i[i] && (ul_ff[i] == OSCSEL_UL_OPEN);
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ul_ff[0] <= OSCSEL_UL_IDLE;
            ul_ff[1] <= OSCSEL_UL_IDLE;
        end
        else if (wr_i)
        begin
            // any write breaks a pending pair, so keys must be back to back
            for (int i = 0; i < 2; i++)
            begin
                logic [7:0] byte_v;
                logic [7:0] key1;
                logic [7:0] key2;
                byte_v = wdata_i[8*i +: 8];
                key1   = (i == 1) ? OSCSEL_KEY_HI_1 : OSCSEL_KEY_LO_1;
                key2   = (i == 1) ? OSCSEL_KEY_HI_2 : OSCSEL_KEY_LO_2;
                if (!(reg_wr && wr_be_i[i]))
                    ul_ff[i] <= OSCSEL_UL_IDLE;
                else if (ul_ff[i] == OSCSEL_UL_KEY1 && byte_v == key2)
                    ul_ff[i] <= OSCSEL_UL_OPEN;
                else if (ul_ff[i] != OSCSEL_UL_OPEN && byte_v == key1)
                    ul_ff[i] <= OSCSEL_UL_KEY1;
                else
                    ul_ff[i] <= OSCSEL_UL_IDLE;
            end
        end
    end

    // register fields
    logic [2:0] cur_src_ff;
    logic [2:0] new_src_ff;
    logic       sel_lock_ff;
    logic       io_lock_ff;
    logic       pll_lock_ff;
    logic       fail_ff;
    logic       pri_sleep_ff;
    logic       sec_en_ff;
    logic       sw_req_ff;
    logic       frozen;

    oscsel_sw_t       sw_ff;
    logic [2:0]       target_ff;
    logic [SET_W-1:0] settle_ff;
    logic [GATE_W-1:0] gate_cnt_ff;
    logic             sw_start;
    logic             sw_abort;
    logic             sw_done;

    assign frozen   = sel_lock_ff && mon_on;
    assign sw_start = (sw_ff == OSCSEL_SW_CHECK) &&
                      (new_src_ff != cur_src_ff) && (new_src_ff != OSCSEL_SRC_RSVD);
    assign sw_abort = (sw_ff == OSCSEL_SW_CHECK) && !sw_start;
    assign sw_done  = (sw_ff == OSCSEL_SW_MUX) && (gate_cnt_ff == '0);

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            new_src_ff <= OSCSEL_SRC_RST;
        else if (!cfg_loaded_ff)
            new_src_ff <= initial_source_cfg_i;
        else if (lane_open[1] && !frozen)
            new_src_ff <= wdata_i[OSCSEL_NEW_LSB +: 3];
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            sw_req_ff <= 1'b0;
        else if (!sw_allowed)
            sw_req_ff <= 1'b0;
        else if (sw_abort || sw_done)
            sw_req_ff <= 1'b0;
        else if (lane_open[0] && !frozen && wdata_i[OSCSEL_SW_REQ])
            sw_req_ff <= 1'b1;
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sel_lock_ff  <= 1'b0;
            pri_sleep_ff <= 1'b0;
            sec_en_ff    <= 1'b0;
        end
        else if (lane_open[0])
        begin
            sel_lock_ff  <= sel_lock_ff | wdata_i[OSCSEL_SEL_LOCK];
            pri_sleep_ff <= wdata_i[OSCSEL_PRI_SLEEP];
            sec_en_ff    <= wdata_i[OSCSEL_SEC_EN];
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            io_lock_ff <= 1'b0;
        else if (lane_open[0] && !(one_way_ff && io_lock_ff))
            io_lock_ff <= wdata_i[OSCSEL_IO_LOCK];
    end

    // monitor event beats a software clear in the same cycle
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            fail_ff <= 1'b0;
        else if (clock_fail_i && mon_on)
            fail_ff <= 1'b1;
        else if (sw_start)
            fail_ff <= 1'b0;
        else if (lane_open[0] && !wdata_i[OSCSEL_FAIL])
            fail_ff <= 1'b0;
    end

    // switch sequencer
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sw_ff       <= OSCSEL_SW_IDLE;
            target_ff   <= OSCSEL_SRC_RST;
            settle_ff   <= '0;
            gate_cnt_ff <= '0;
        end
        else
        begin
            unique case (sw_ff)
                OSCSEL_SW_IDLE:
                    if (sw_req_ff && sw_allowed)
                        sw_ff <= OSCSEL_SW_CHECK;
                OSCSEL_SW_CHECK:
                begin
                    target_ff <= new_src_ff;
                    settle_ff <= SET_W'(SETTLE_CYCLES);
                    sw_ff     <= sw_start ? OSCSEL_SW_WAIT : OSCSEL_SW_IDLE;
                end
                OSCSEL_SW_WAIT:
                    // source must be up, and the pll locked where it is used
                    if ((ready_s & src_uses(target_ff)) == src_uses(target_ff) &&
                        (pll_lock_s || !src_pll(target_ff, pmode_ff)))
                        sw_ff <= OSCSEL_SW_SETTLE;
                OSCSEL_SW_SETTLE:
                    if (settle_ff == '0)
                    begin
                        gate_cnt_ff <= GATE_W'(GATE_CYCLES);
                        sw_ff       <= OSCSEL_SW_GATE;
                    end
                    else if (new_clk_rise)
                        settle_ff <= settle_ff - SET_W'(1);
                OSCSEL_SW_GATE:
                    if (gate_cnt_ff == '0)
                    begin
                        gate_cnt_ff <= GATE_W'(GATE_CYCLES);
                        sw_ff       <= OSCSEL_SW_MUX;
                    end
                    else
                        gate_cnt_ff <= gate_cnt_ff - GATE_W'(1);
                OSCSEL_SW_MUX:
                    if (gate_cnt_ff == '0)
                        sw_ff <= OSCSEL_SW_IDLE;
                    else
                        gate_cnt_ff <= gate_cnt_ff - GATE_W'(1);
                default:
                    sw_ff <= OSCSEL_SW_IDLE;
            endcase
        end
    end

    // current source follows config at load, target at commit
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cur_src_ff <= OSCSEL_SRC_RST;
        else if (!cfg_loaded_ff)
            cur_src_ff <= initial_source_cfg_i;
        else if (sw_done)
            cur_src_ff <= target_ff;
    end

    // clock gated off around the mux change so no runt pulse reaches the core
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            clk_gate_o    <= 1'b0;
            clk_mux_sel_o <= OSCSEL_SRC_RST;
        end
        else if (!cfg_loaded_ff)
        begin
            clk_mux_sel_o <= initial_source_cfg_i;
        end
        else
        begin
            clk_gate_o <= (sw_ff != OSCSEL_SW_GATE) && !(sw_ff == OSCSEL_SW_MUX &&
                          gate_cnt_ff != '0);
            if (sw_ff == OSCSEL_SW_MUX)
                clk_mux_sel_o <= target_ff;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            pll_lock_ff <= 1'b0;
        else if (sw_ff != OSCSEL_SW_IDLE || !src_pll(cur_src_ff, pmode_ff))
            pll_lock_ff <= 1'b0;
        else
            pll_lock_ff <= pll_lock_s;
    end

    // oscillator and pll enables
    logic [3:0] nxt_osc_en;
    logic       switching;
    assign switching = (sw_ff != OSCSEL_SW_IDLE) && (sw_ff != OSCSEL_SW_CHECK);

    always_comb
    begin
        nxt_osc_en = src_uses(cur_src_ff) | (switching ? src_uses(target_ff) : 4'h0);
        nxt_osc_en[1] = nxt_osc_en[1] | sec_en_ff;
        nxt_osc_en[3] = nxt_osc_en[3] | mon_on;
        if (sleep_i && !pri_sleep_ff)
            nxt_osc_en[0] = 1'b0;
        if (!cfg_loaded_ff)
            nxt_osc_en = 4'h0;
    end

    // instruction clock toggles each processor clock
    logic pin_fcy;
    assign pin_fcy = (cur_src_ff == OSCSEL_SRC_PRI || cur_src_ff == OSCSEL_SRC_PRI_PLL) ?
                     (pmode_ff == OSCSEL_PMODE_EXT) : pin_fn_ff;

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            osc_enable_o         <= 4'h0;
            pll_enable_o         <= 1'b0;
            primary_mode_o       <= OSCSEL_PMODE_OFF;
            fail_safe_monitor_o  <= 1'b0;
            io_lock_a_o          <= 1'b0;
            fcy_o                <= 1'b0;
            osc_output_pin_fcy_o <= 1'b0;
        end
        else
        begin
            osc_enable_o         <= nxt_osc_en;
            pll_enable_o         <= cfg_loaded_ff && (src_pll(cur_src_ff, pmode_ff) ||
                                    (switching && src_pll(target_ff, pmode_ff)));
            primary_mode_o       <= pmode_ff;
            fail_safe_monitor_o  <= mon_on;
            io_lock_a_o          <= io_lock_ff;
            fcy_o                <= ~fcy_o;
            osc_output_pin_fcy_o <= cfg_loaded_ff && pin_fcy;
        end
    end

    // read port: data valid the cycle after the strobe, zero elsewhere
    logic [15:0] reg_view;
    always_comb
    begin
        reg_view = 16'h0000;
        reg_view[OSCSEL_CUR_LSB +: 3] = cur_src_ff;
        reg_view[OSCSEL_NEW_LSB +: 3] = new_src_ff;
        reg_view[OSCSEL_SEL_LOCK]     = sel_lock_ff;
        reg_view[OSCSEL_IO_LOCK]      = io_lock_ff;
        reg_view[OSCSEL_PLL_LOCK]     = pll_lock_ff;
        reg_view[OSCSEL_FAIL]         = fail_ff;
        reg_view[OSCSEL_PRI_SLEEP]    = pri_sleep_ff;
        reg_view[OSCSEL_SEC_EN]       = sec_en_ff;
        reg_view[OSCSEL_SW_REQ]       = sw_req_ff;
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_o <= OSCSEL_RDATA_RST;
        else
            rdata_o <= reg_rd ? reg_view : 16'h0000;
    end

endmodule : oscsel_ctrl

// *** bench/oscsel_ctrl_props.sv ***
/* oscsel_ctrl_props: port checks for oscsel_ctrl.
   Assumes config inputs change only while reset is held. */
`timescale 1ns/100ps
module oscsel_ctrl_props (
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    input  wire logic        rd_i,
    input  wire logic [2:0]  initial_source_cfg_i,
    input  wire logic [1:0]  primary_mode_cfg_i,
    input  wire logic [1:0]  switch_monitor_cfg_i,
    input  wire logic [15:0] rdata_o,
    input  wire logic [2:0]  clk_mux_sel_o,
    input  wire logic        clk_gate_o,
    input  wire logic [1:0]  primary_mode_o,
    input  wire logic        fail_safe_monitor_o,
    input  wire logic        fcy_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    a_fcy_half: assert property ($past(rst_b_i) |-> fcy_o != $past(fcy_o))
        else $error("fcy stuck");
    a_boot_src: assert property ($past(rst_b_i, 2) && !$past(rst_b_i, 3)
        |-> clk_mux_sel_o == initial_source_cfg_i) else $error("boot source");
    a_pmode_cfg: assert property ($past(rst_b_i, 2) |-> primary_mode_o == primary_mode_cfg_i)
        else $error("primary mode");
    a_mon_cfg: assert property ($past(rst_b_i, 2)
        |-> fail_safe_monitor_o == (switch_monitor_cfg_i == 2'h0)) else $error("monitor");
    a_unimpl_zero: assert property ($past(rd_i) |-> {rdata_o[15], rdata_o[11], rdata_o[4]} == 3'h0)
        else $error("unimplemented bits");
    a_pll_stat: assert property ($past(rd_i) && !(rdata_o[14:12] inside {3'h1, 3'h3})
        |-> !rdata_o[5]) else $error("pll status");
    a_mux_gated: assert property ($changed(clk_mux_sel_o)
        |-> !clk_gate_o && !$past(clk_gate_o) ##[1:2] clk_gate_o) else $error("ungated mux change");
    a_no_switch: assert property (switch_monitor_cfg_i[1] && $past(rst_b_i, 2)
        |-> $stable(clk_mux_sel_o) && !(rdata_o[0] && $past(rd_i))) else $error("switch");
    c_switch: cover property ($changed(clk_mux_sel_o));
    c_gate_up: cover property (!clk_gate_o ##1 clk_gate_o);
    c_pll_read: cover property ($past(rd_i) && rdata_o[5]);
endmodule : oscsel_ctrl_props
bind oscsel_ctrl oscsel_ctrl_props oscsel_ctrl_props_inst (.*);

// *** bench/oscsel_osc_model.sv ***
/* oscsel_osc_model: oscillators, pll and new-source clock.
   Assumes enables from oscsel_ctrl; slow_i stretches start-up. */
`timescale 1ns/100ps
module oscsel_osc_model (
    input  wire logic       clock_i,
    input  wire logic [3:0] osc_enable_i,
    input  wire logic       pll_enable_i,
    input  wire logic       slow_i,
    output logic [3:0]      osc_ready_o,
    output logic            pll_lock_o,
    output logic            new_clk_o
);
    int   cnt [5];
    logic [4:0] en;
    assign en = {pll_enable_i, osc_enable_i};
    logic nclk = 1'b0;
    // runs free; rate under a quarter of clock_i so the filter sees each level
    always #20 nclk = ~nclk;
    assign new_clk_o = nclk;
    always_ff @(posedge clock_i)
        for (int i = 0; i < 5; i++)
            cnt[i] <= en[i] ? cnt[i] + 1 : 0;
    always_comb
        for (int i = 0; i < 4; i++)
            osc_ready_o[i] = cnt[i] > (slow_i ? 200 : 8);
    assign pll_lock_o = cnt[4] > (slow_i ? 200 : 8);
endmodule : oscsel_osc_model

// *** bench/oscsel_ctrl_tb_top.sv ***
/* oscsel_ctrl_tb_top: directed bench for oscsel_ctrl.
   Assumes the oscillator model answers enables with ready and lock. */
`timescale 1ns/100ps
module oscsel_ctrl_tb_top;
    logic        clock_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, slow = 1'b0;
    logic        clock_fail_i = 1'b0, sleep_i = 1'b0, osc_out_pin_function_cfg_i = 1'b0;
    logic        io_lock_one_way_cfg_i = 1'b1, pll_lock_i, new_clk_i, clk_gate_o, fcy_o;
    logic        pll_enable_o, fail_safe_monitor_o, io_lock_a_o, osc_output_pin_fcy_o;
    logic [7:0]  addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000, rdata_o, r;
    logic [1:0]  wr_be_i = 2'h0, primary_mode_cfg_i = 2'h3, switch_monitor_cfg_i = 2'h3;
    logic [1:0]  primary_mode_o;
    logic [2:0]  initial_source_cfg_i = 3'h7, clk_mux_sel_o;
    logic [3:0]  osc_ready_i, osc_enable_o;
    int          fail_count = 0, n_compared = 0;
    always #4 clock_i = ~clock_i;
    oscsel_ctrl oscsel_ctrl_inst (.*);
    oscsel_osc_model oscsel_osc_model_inst (.clock_i, .osc_enable_i(osc_enable_o),
        .pll_enable_i(pll_enable_o), .slow_i(slow), .osc_ready_o(osc_ready_i),
        .pll_lock_o(pll_lock_i), .new_clk_o(new_clk_i));
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task wr(input logic [1:0] be, input logic [15:0] d);
        @(posedge clock_i);
        wr_i    <= 1'b1;
        wr_be_i <= be;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask : wr
    task hi(input logic [2:0] s);
        wr(2'h2, 16'h7800);
        wr(2'h2, 16'h9a00);
        wr(2'h2, {5'h00, s, 8'h00});
    endtask : hi
    task lo(input logic [7:0] v);
        wr(2'h1, 16'h0046);
        wr(2'h1, 16'h0057);
        wr(2'h1, {8'h00, v});
    endtask : lo
    task rd(input logic [7:0] a);
        @(posedge clock_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        addr_i <= 8'h00;
        #1 r = rdata_o;
    endtask : rd
    task settle;
        repeat (3) @(posedge clock_i);
        #1;
    endtask : settle
    task boot(input logic [2:0] s, input logic [1:0] m);
        rst_b_i              <= 1'b0;
        initial_source_cfg_i <= s;
        switch_monitor_cfg_i <= m;
        primary_mode_cfg_i   <= 2'h1;
        repeat (6) @(posedge clock_i);
        rst_b_i              <= 1'b1;
        settle();
    endtask : boot
    // a switch completes when the request bit drops; bounded poll
    task wait_done;
        for (int i = 0; i < 300; i++)
        begin
            rd(8'h00);
            if (r[0] === 1'b0)
                return;
        end
        chk("switch timeout", 16'h0000, 16'h0001);
        tally_and_finish();
    endtask : wait_done
    task t_disabled;
        boot(3'h7, 2'h3);
        rd(8'h00);
        chk("reset value", 16'h7700, r);
        hi(3'h0);
        lo(8'h01);
        rd(8'h00);
        chk("switch held off", 16'h7000, r & 16'h7701);
        rd(8'h04);
        chk("unmapped read", 16'h0000, r);
        $display("disabled done");
    endtask : t_disabled
    task t_switch;
        boot(3'h7, 2'h1);
        wr(2'h2, 16'h0200);
        rd(8'h00);
        chk("keyless write", 16'h0700, r & 16'h0700);
        hi(3'h2);
        lo(8'h01);
        wait_done();
        chk("primary", 16'h2200, r & 16'h7701);
        slow <= 1'b1;
        hi(3'h3);
        lo(8'h01);
        wait_done();
        settle();
        rd(8'h00);
        chk("pll source", 16'h3320, r & 16'h7721);
        chk("pll enable", 16'h0001, {15'h0000, pll_enable_o});
        lo(8'h01);
        settle();
        rd(8'h00);
        chk("redundant", 16'h3320, r & 16'h7721);
        sleep_i <= 1'b1;
        lo(8'h06);
        settle();
        chk("sleep keep", 16'h0003, {14'h0000, osc_enable_o[1:0]});
        lo(8'h40);
        settle();
        chk("sleep stop", 16'h0000, {14'h0000, osc_enable_o[1:0]});
        sleep_i <= 1'b0;
        lo(8'h80);
        hi(3'h0);
        rd(8'h00);
        chk("io lock one way", 16'h0040, r & 16'h0040);
        chk("io lock out", 16'h0001, {15'h0000, io_lock_a_o});
        chk("unlocked select", 16'h0000, r & 16'h0700);
        $display("switch done");
    endtask : t_switch
    task t_monitor;
        osc_out_pin_function_cfg_i <= 1'b1;
        boot(3'h0, 2'h0);
        chk("osc pin fcy", 16'h0001, {15'h0000, osc_output_pin_fcy_o});
        clock_fail_i <= 1'b1;
        @(posedge clock_i);
        clock_fail_i <= 1'b0;
        rd(8'h00);
        chk("fail set", 16'h0008, r & 16'h0008);
        lo(8'h80);
        hi(3'h5);
        rd(8'h00);
        chk("fail cleared", 16'h0080, r & 16'h0088);
        chk("locked select", 16'h0000, r & 16'h0700);
        $display("monitor done");
    endtask : t_monitor
    initial
    begin
        t_disabled();
        t_switch();
        t_monitor();
        tally_and_finish();
    end
endmodule : oscsel_ctrl_tb_top
